// ===== phy_port_regs_pkg.sv
/*
  Register addresses, field positions, reset values and codes shared by
  the port-status register bank and its per-port unit.
  Assumes a 4-bit register address and 8-bit register data, as carried
  by the link's PHY control register.
*/
package phy_port_regs_pkg;
  // register addresses
  localparam logic [3:0] ADDR_SELFID = 4'h4;
  localparam logic [3:0] ADDR_EVENT = 4'h5;
  localparam logic [3:0] ADDR_SELECT = 4'h7;
  localparam logic [3:0] ADDR_PORT_LINE = 4'h8;
  localparam logic [3:0] ADDR_PORT_SPEED = 4'h9;
  localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;
  // self-id control register
  localparam int SID_PWR_LSB = 5;
  localparam int SID_JITTER_LSB = 2;
  localparam int SID_CONT = 1;
  localparam logic [2:0] JITTER_CODE = 3'h0;
  // event register
  localparam int EV_MULTI = 7;
  localparam int EV_ACCEL = 6;
  localparam int EV_PORT = 5;
  localparam int EV_TOUT = 4;
  localparam int EV_PFAIL = 3;
  localparam int EV_LOOP = 2;
  localparam int EV_SBR = 1;
  localparam int EV_NOTIFY = 0;
  localparam logic PFAIL_RESET = 1'h1;
  // select register
  localparam int SEL_PORT_LSB = 4;
  localparam int SEL_PAGE_LSB = 0;
  // page 0 line/connection status
  localparam int LN_ASTAT_LSB = 6;
  localparam int LN_BSTAT_LSB = 4;
  localparam int LN_CHILD = 3;
  localparam int LN_CONN = 2;
  localparam int LN_BIAS = 1;
  localparam int LN_DIS = 0;
  // page 0 speed / fault / interrupt enable
  localparam int SP_SPEED_LSB = 5;
  localparam int SP_PORT_CHANGE_IRQ_ENABLE = 4;
  localparam int SP_FAULT = 3;
  // line state codes
  localparam logic [1:0] LINE_INVALID = 2'h0;
  localparam logic [1:0] LINE_ONE = 2'h1;
  localparam logic [1:0] LINE_ZERO = 2'h2;
  localparam logic [1:0] LINE_HIGHZ = 2'h3;
  // negotiated speed codes
  localparam logic [2:0] SPEED_S100 = 3'h0;
  localparam logic [2:0] SPEED_S200 = 3'h1;
  localparam logic [2:0] SPEED_S400 = 3'h2;
  // strap capture timing after reset release
  localparam logic [1:0] STRAP_LOAD_CYCLE = 2'h2;
  localparam logic [1:0] STRAP_DONE_CYCLE = 2'h3;
  localparam int FILTER_CYCLES_DEFAULT = 16;
endpackage

// ===== port_regs_if.sv
/*
  Per-port window signals between the register bank and one port unit.
  Assumes one instance per port, all on the PHY system clock.
*/
interface port_regs_if;
  logic wr_line;
  logic wr_speed;
  logic [7:0] wdata;
  logic [7:0] line_byte;
  logic [7:0] speed_byte;
  logic change_event;
  modport regs(
    output wr_line,
    output wr_speed,
    output wdata,
    input line_byte,
    input speed_byte,
    input change_event
  );
  modport port(
    input wr_line,
    input wr_speed,
    input wdata,
    output line_byte,
    output speed_byte,
    output change_event
  );
endinterface

// ===== port_status_unit.sv
/*
  Status and control of one cable port: filtered connect and bias,
  disabled bit with strap default, interrupt enable, sticky fault and
  change detection towards the port event flag.
  Assumes its inputs are already synchronised to clk.
*/
module port_status_unit
  import phy_port_regs_pkg::*;
#(
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load_straps,
  input wire logic strap_disabled,
  input wire logic connect_in,
  input wire logic bias_in,
  input wire logic [1:0] astat,
  input wire logic [1:0] bstat,
  input wire logic child,
  input wire logic [2:0] speed,
  input wire logic fault_error,
  port_regs_if.port pr
);
  localparam logic [15:0] FILT_LAST = 16'(FILTER_CYCLES - 1);

  logic [1:0] filt, next_filt;
  logic [15:0] cnt [2];
  logic [15:0] next_cnt [2];
  logic disabled, next_disabled;
  logic int_en, next_int_en;
  logic fault, next_fault;
  logic [3:0] prev_state, next_prev_state;
  logic [1:0] raw;
  logic [3:0] state;

  generate
    if (FILTER_CYCLES < 1 || FILTER_CYCLES > 65535) begin : g_bad
      $error("FILTER_CYCLES out of range");
    end
  endgenerate

  assign raw = {bias_in, connect_in};
  assign state = {fault, disabled, filt};

  always_comb begin
    next_filt = filt;
    for (int i = 0; i < 2; i++) begin
      next_cnt[i] = 16'h0000;
      if (raw[i] != filt[i]) begin
        // a new level must hold for the whole filter time
        if (cnt[i] == FILT_LAST) begin
          next_filt[i] = raw[i];
        end else begin
          next_cnt[i] = cnt[i] + 16'h0001;
        end
      end
    end
    next_disabled = disabled;
    if (load_straps) begin
      next_disabled = strap_disabled;
    end else if (pr.wr_line) begin
      next_disabled = pr.wdata[LN_DIS];
    end
    next_int_en = pr.wr_speed ? pr.wdata[SP_PORT_CHANGE_IRQ_ENABLE] : int_en;
    // an error in the clearing cycle still sets the bit
    next_fault = fault_error |
                 (fault & ~(pr.wr_speed & pr.wdata[SP_FAULT]));
    next_prev_state = state;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt <= 2'h0;
      cnt[0] <= 16'h0000;
      cnt[1] <= 16'h0000;
      disabled <= 1'b0;
      int_en <= 1'b0;
      fault <= 1'b0;
      prev_state <= 4'h0;
    end else begin
      filt <= next_filt;
      cnt[0] <= next_cnt[0];
      cnt[1] <= next_cnt[1];
      disabled <= next_disabled;
      int_en <= next_int_en;
      fault <= next_fault;
      prev_state <= next_prev_state;
    end
  end

  assign pr.change_event = int_en & (|(state ^ prev_state));
  assign pr.line_byte = {astat, bstat, child, filt[0], filt[1],
                         disabled};
  assign pr.speed_byte = {speed, int_en, fault, 3'h0};
endmodule // port_status_unit

// ===== serial_bus_phy_port_registers.sv
/*
  Self-id control, event flags, page/port select and the port status
  page of a three-port cable PHY register set.
  Assumes the link reaches it through its PHY control register, giving
  a 4-bit address, 8-bit data and one-cycle read and write strobes on
  the PHY system clock; event inputs are one-cycle pulses on clk, pins
  and analog detector outputs are asynchronous.
*/
// Summary of operation
// - contender bit feeds first self-id packet
// - strapped power class copied into self-id
// - jitter field always reads zero
// - notify enable reports events during link sleep
// - short reset request clears after reset
// - loop flag sticky, write one clears
// - power fail on status change, resets one
// - arbitration timeout flag sticky, write one clears
// - port event on enabled change or resume
// - acceleration and concatenation enables drive arbitration
// - page select chooses window page
// - port select chooses window port
// - line states report two-bit codes
// - child bit shows child or parent
// - connected bit filtered against contact bounce
// - bias bit filtered against contact bounce
// - disabled bit, strap default, disables port
// - negotiated speed read-only three-bit code
// - interrupt enable gates port change events
// - fault sticky on suspend/resume error
// - all access through link control register
module serial_bus_phy_port_registers
  import phy_port_regs_pkg::*;
#(
  parameter int N_PORTS = 3,
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] power_class_straps,
  input wire logic contender_strap,
  input wire logic [N_PORTS-1:0] disable_straps,
  input wire logic cable_power_present,
  input wire logic loop_detected,
  input wire logic arb_timeout,
  input wire logic short_reset_done,
  input wire logic link_asleep,
  input wire logic resume_irq_enable,
  input wire logic [N_PORTS-1:0] resume_start,
  input wire logic [N_PORTS-1:0] port_connect_raw,
  input wire logic [N_PORTS-1:0] port_bias_raw,
  input wire logic [2*N_PORTS-1:0] port_astat_raw,
  input wire logic [2*N_PORTS-1:0] port_bstat_raw,
  input wire logic [N_PORTS-1:0] port_child,
  input wire logic [3*N_PORTS-1:0] port_speed,
  input wire logic [N_PORTS-1:0] port_fault_error,
  output logic selfid_contender,
  output logic [2:0] selfid_power_class,
  output logic sleep_notify_enable,
  output logic short_arbitrated_reset_request,
  output logic accel_arb_enable,
  output logic multi_speed_enable,
  output logic [N_PORTS-1:0] port_disabled,
  output logic link_wake_irq
);
  // straps, power, per-port connect, bias, disable and line codes
  localparam int SW = 5 + 7 * N_PORTS;

  generate
    if (N_PORTS < 1 || N_PORTS > 15) begin : g_bad
      $error("N_PORTS must be 1 to 15");
    end
  endgenerate

  // two-flop synchronisers for everything from pins or analog detectors
  logic [SW-1:0] sync_raw, sync_a, sync_b;
  assign sync_raw = {port_bstat_raw, port_astat_raw, port_bias_raw,
                     port_connect_raw, disable_straps, cable_power_present,
                     contender_strap, power_class_straps};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= sync_raw;
      sync_b <= sync_a;
    end
  end

  logic [2:0] s_pclass;
  logic s_contender, s_power;
  logic [N_PORTS-1:0] s_disable, s_connect, s_bias;
  logic [2*N_PORTS-1:0] s_astat, s_bstat;
  assign s_pclass = sync_b[2:0];
  assign s_contender = sync_b[3];
  assign s_power = sync_b[4];
  assign s_disable = sync_b[5 +: N_PORTS];
  assign s_connect = sync_b[5+N_PORTS +: N_PORTS];
  assign s_bias = sync_b[5+2*N_PORTS +: N_PORTS];
  assign s_astat = sync_b[5+3*N_PORTS +: 2*N_PORTS];
  assign s_bstat = sync_b[5+5*N_PORTS +: 2*N_PORTS];

  // strap capture once the synchronisers carry valid pin levels
  logic [1:0] strap_cnt, next_strap_cnt;
  logic load_straps, armed;
  assign load_straps = (strap_cnt == STRAP_LOAD_CYCLE);
  assign armed = (strap_cnt == STRAP_DONE_CYCLE);

  // write decode
  logic wr_sid, wr_ev, wr_sel, window_ok;
  assign wr_sid = reg_wr & (reg_addr == ADDR_SELFID);
  assign wr_ev = reg_wr & (reg_addr == ADDR_EVENT);
  assign wr_sel = reg_wr & (reg_addr == ADDR_SELECT);

  // control and flag state
  logic contender, next_contender;
  logic [2:0] pclass, next_pclass;
  logic notify_en, next_notify_en;
  logic sbr_req, next_sbr_req;
  logic loop_flag, next_loop_flag;
  logic pfail_flag, next_pfail_flag;
  logic tout_flag, next_tout_flag;
  logic pevent_flag, next_pevent_flag;
  logic accel_en, next_accel_en;
  logic multi_en, next_multi_en;
  logic [2:0] page_sel, next_page_sel;
  logic [3:0] port_sel, next_port_sel;
  logic power_prev, next_power_prev;
  logic wake, next_wake;
  logic [7:0] rdata, next_rdata;

  logic pwr_change, any_port_change;
  logic [N_PORTS-1:0] port_change;
  logic [7:0] line_bytes [N_PORTS];
  logic [7:0] speed_bytes [N_PORTS];

  // power change only counts once the synchronised level has settled
  assign pwr_change = armed & (s_power != power_prev);
  assign any_port_change = |port_change;
  // the window answers only for page 0 and a port that exists
  assign window_ok = (page_sel == PAGE_PORT_STATUS) &
                     (port_sel < 4'(N_PORTS));

  always_comb begin
    // counter parks at the armed value until the next reset
    next_strap_cnt = armed ? strap_cnt : strap_cnt + 2'h1;
    next_contender = contender;
    next_pclass = pclass;
    if (load_straps) begin
      next_contender = s_contender;
      next_pclass = s_pclass;
    end else if (wr_sid) begin
      next_contender = reg_wdata[SID_CONT];
      next_pclass = reg_wdata[SID_PWR_LSB +: 3];
    end
    next_notify_en = wr_ev ? reg_wdata[EV_NOTIFY] : notify_en;
    next_accel_en = wr_ev ? reg_wdata[EV_ACCEL] : accel_en;
    next_multi_en = wr_ev ? reg_wdata[EV_MULTI] : multi_en;
    // request stays until the arbitrated short reset has gone out
    next_sbr_req = (wr_ev & reg_wdata[EV_SBR]) |
                   (sbr_req & ~short_reset_done);
    // hardware set wins over a write-one clear in the same cycle
    next_loop_flag = loop_detected |
                     (loop_flag & ~(wr_ev & reg_wdata[EV_LOOP]));
    next_pfail_flag = pwr_change |
                      (pfail_flag & ~(wr_ev & reg_wdata[EV_PFAIL]));
    next_tout_flag = arb_timeout |
                     (tout_flag & ~(wr_ev & reg_wdata[EV_TOUT]));
    next_pevent_flag = any_port_change |
                       (resume_irq_enable & (|resume_start)) |
                       (pevent_flag & ~(wr_ev & reg_wdata[EV_PORT]));
    next_page_sel = wr_sel ? reg_wdata[SEL_PAGE_LSB +: 3] : page_sel;
    next_port_sel = wr_sel ? reg_wdata[SEL_PORT_LSB +: 4] : port_sel;
    next_power_prev = s_power;
    // wake pulse for sleep-time events and for any resume start
    next_wake = notify_en &
                ((link_asleep & (loop_detected | pwr_change | arb_timeout)) |
                 (|resume_start));
    // read data holds between reads; a same-cycle write is not yet seen
    next_rdata = rdata;
    if (reg_rd) begin
      next_rdata = 8'h00;
      case (reg_addr)
        ADDR_SELFID: begin
          next_rdata[SID_PWR_LSB +: 3] = pclass;
          next_rdata[SID_JITTER_LSB +: 3] = JITTER_CODE;
          next_rdata[SID_CONT] = contender;
        end
        ADDR_EVENT: begin
          next_rdata = {multi_en, accel_en, pevent_flag, tout_flag,
                        pfail_flag, loop_flag, sbr_req, notify_en};
        end
        ADDR_SELECT: begin
          next_rdata[SEL_PORT_LSB +: 4] = port_sel;
          next_rdata[SEL_PAGE_LSB +: 3] = page_sel;
        end
        ADDR_PORT_LINE: begin
          for (int i = 0; i < N_PORTS; i++) begin
            if (window_ok && port_sel == 4'(i)) begin
              next_rdata = line_bytes[i];
            end
          end
        end
        ADDR_PORT_SPEED: begin
          for (int i = 0; i < N_PORTS; i++) begin
            if (window_ok && port_sel == 4'(i)) begin
              next_rdata = speed_bytes[i];
            end
          end
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_cnt <= 2'h0;
      contender <= 1'b0;
      pclass <= 3'h0;
      notify_en <= 1'b0;
      sbr_req <= 1'b0;
      loop_flag <= 1'b0;
      pfail_flag <= PFAIL_RESET;
      tout_flag <= 1'b0;
      pevent_flag <= 1'b0;
      accel_en <= 1'b0;
      multi_en <= 1'b0;
      page_sel <= 3'h0;
      port_sel <= 4'h0;
      power_prev <= 1'b0;
      wake <= 1'b0;
      rdata <= 8'h00;
    end else begin
      strap_cnt <= next_strap_cnt;
      contender <= next_contender;
      pclass <= next_pclass;
      notify_en <= next_notify_en;
      sbr_req <= next_sbr_req;
      loop_flag <= next_loop_flag;
      pfail_flag <= next_pfail_flag;
      tout_flag <= next_tout_flag;
      pevent_flag <= next_pevent_flag;
      accel_en <= next_accel_en;
      multi_en <= next_multi_en;
      page_sel <= next_page_sel;
      port_sel <= next_port_sel;
      power_prev <= next_power_prev;
      wake <= next_wake;
      rdata <= next_rdata;
    end
  end

  // one status unit per cable port
  generate
    for (genvar g = 0; g < N_PORTS; g++) begin : g_port
      port_regs_if pr();
      // window writes reach only the selected, existing port
      assign pr.wr_line = reg_wr & (reg_addr == ADDR_PORT_LINE) &
                          window_ok & (port_sel == 4'(g));
      assign pr.wr_speed = reg_wr & (reg_addr == ADDR_PORT_SPEED) &
                           window_ok & (port_sel == 4'(g));
      assign pr.wdata = reg_wdata;
      assign line_bytes[g] = pr.line_byte;
      assign speed_bytes[g] = pr.speed_byte;
      assign port_change[g] = pr.change_event;
      assign port_disabled[g] = pr.line_byte[LN_DIS];
      port_status_unit #(
        .FILTER_CYCLES(FILTER_CYCLES)
      ) u_port (
        .clk(clk),
        .rst(rst),
        .load_straps(load_straps),
        .strap_disabled(s_disable[g]),
        .connect_in(s_connect[g]),
        .bias_in(s_bias[g]),
        .astat(s_astat[2*g +: 2]),
        .bstat(s_bstat[2*g +: 2]),
        .child(port_child[g]),
        .speed(port_speed[3*g +: 3]),
        .fault_error(port_fault_error[g]),
        .pr(pr.port)
      );
    end
  endgenerate

  // register state towards self-id, arbitration and the link
  assign reg_rdata = rdata;
  assign selfid_contender = contender;
  assign selfid_power_class = pclass;
  assign sleep_notify_enable = notify_en;
  assign short_arbitrated_reset_request = sbr_req;
  assign accel_arb_enable = accel_en;
  assign multi_speed_enable = multi_en;
  assign link_wake_irq = wake;
endmodule // serial_bus_phy_port_registers

// ===== link_model.sv
/*
  Behavioural model of the link side of the PHY control register path:
  issues register reads and writes and selects the window page and port.
  Assumes the one-cycle strobe protocol on the PHY system clock.
*/
module link_model
  import phy_port_regs_pkg::*;
(
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // released address and data lines show the inverse, not the last value
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // page and port go to the select register before any window access
  task automatic sel(input logic [3:0] port, input logic [2:0] page);
    wr(ADDR_SELECT, {port, 1'b0, page});
  endtask
endmodule // link_model

// ===== serial_bus_phy_port_registers_monitor.sv
/*
  Concurrent checks on the port-register bank's top ports.
  Assumes one clock, clk, and an asynchronous active-high rst.
*/
module serial_bus_phy_port_registers_monitor
  import phy_port_regs_pkg::*;
#(
  parameter int N_PORTS = 3,
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic loop_detected,
  input wire logic link_asleep,
  input wire logic [N_PORTS-1:0] resume_start,
  input wire logic short_reset_done,
  input wire logic selfid_contender,
  input wire logic [2:0] selfid_power_class,
  input wire logic sleep_notify_enable,
  input wire logic short_arbitrated_reset_request,
  input wire logic accel_arb_enable,
  input wire logic multi_speed_enable,
  input wire logic link_wake_irq
);
  logic [2:0] age;
  logic [2:0] next_age;
  logic wr_ev;
  logic sbr_wr;

  // strap load overrides self-id writes up to the third edge after reset
  always_comb next_age = (age == 3'h7) ? age : age + 3'h1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) age <= 3'h0;
    else age <= next_age;
  end
  assign wr_ev = reg_wr && reg_addr == ADDR_EVENT;
  assign sbr_wr = wr_ev && reg_wdata[EV_SBR];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sbr_raise: assert property (
    sbr_wr |=> short_arbitrated_reset_request)
    else $error("short reset request not raised");
  a_sbr_drop: assert property (
    short_reset_done && !sbr_wr |=> !short_arbitrated_reset_request)
    else $error("short reset request not cleared");
  a_sbr_hold: assert property (
    short_arbitrated_reset_request && !short_reset_done
      |=> short_arbitrated_reset_request)
    else $error("short reset request dropped early");
  a_notify_write: assert property (
    wr_ev |=> sleep_notify_enable == $past(reg_wdata[EV_NOTIFY]))
    else $error("notify enable does not follow write");
  a_arb_enables: assert property (
    wr_ev |=> accel_arb_enable == $past(reg_wdata[EV_ACCEL])
      && multi_speed_enable == $past(reg_wdata[EV_MULTI]))
    else $error("arbitration enables do not follow write");
  a_selfid_write: assert property (
    reg_wr && reg_addr == ADDR_SELFID && age > 3'h2
      |=> selfid_contender == $past(reg_wdata[SID_CONT])
      && selfid_power_class == $past(reg_wdata[7:5]))
    else $error("self-id fields do not follow write");
  a_wake_loop: assert property (
    sleep_notify_enable && link_asleep && loop_detected |=> link_wake_irq)
    else $error("no wake indication for loop in sleep");
  a_wake_resume: assert property (
    sleep_notify_enable && |resume_start |=> link_wake_irq)
    else $error("no wake indication for resume");
  a_wake_off: assert property (
    !sleep_notify_enable |=> !link_wake_irq)
    else $error("wake indication while notify disabled");
  a_hole_zero: assert property (
    reg_rd && reg_addr == 4'h6 |=> reg_rdata == 8'h00)
    else $error("reserved address reads nonzero");
  a_jitter_zero: assert property (
    reg_rd && reg_addr == ADDR_SELFID
      |=> reg_rdata[4:2] == JITTER_CODE && !reg_rdata[0])
    else $error("jitter or reserved bit nonzero");
endmodule // serial_bus_phy_port_registers_monitor

bind serial_bus_phy_port_registers serial_bus_phy_port_registers_monitor #(
  .N_PORTS(N_PORTS), .FILTER_CYCLES(FILTER_CYCLES)
) monitor_i (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .loop_detected(loop_detected), .link_asleep(link_asleep),
  .resume_start(resume_start), .short_reset_done(short_reset_done),
  .selfid_contender(selfid_contender),
  .selfid_power_class(selfid_power_class),
  .sleep_notify_enable(sleep_notify_enable),
  .short_arbitrated_reset_request(short_arbitrated_reset_request),
  .accel_arb_enable(accel_arb_enable),
  .multi_speed_enable(multi_speed_enable), .link_wake_irq(link_wake_irq)
);

// ===== test_serial_bus_phy_port_registers.sv
/*
  Self-checking bench for the port-register bank, driving registers
  through the link model. Assumes a three-port build, short filter.
*/
module test_serial_bus_phy_port_registers
  import phy_port_regs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic [1:0] ev = 2'b00;
  logic pwr = 1'b1, sbr_done = 1'b0, asleep = 1'b1, res_en = 1'b1;
  logic [2:0] resume = 3'h0, fault = 3'h0, conn = 3'h0, bias = 3'h0;
  logic [2:0] child = 3'h0;
  logic [5:0] astat = 6'h00, bstat = 6'h00;
  logic [8:0] speed = 9'h000;
  logic contender, notify, sbr_req, accel, multi, wake;
  logic [2:0] pclass, disabled;
  logic [7:0] ev_mask [3] = '{8'h04, 8'h10, 8'h08};
  logic [7:0] line_exp [3] = '{8'hF0, 8'h9C, 8'h02};
  logic [7:0] spd_exp [3] = '{8'h00, 8'h40, 8'h20};
  int bad_count = 0;
  int n_compared = 0;

  always #20 clk = ~clk;

  serial_bus_phy_port_registers #(.N_PORTS(3), .FILTER_CYCLES(2))
    serial_bus_phy_port_registers_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .power_class_straps(3'h5), .contender_strap(1'b1),
    .disable_straps(3'h0), .cable_power_present(pwr),
    .loop_detected(ev[0]), .arb_timeout(ev[1]),
    .short_reset_done(sbr_done), .link_asleep(asleep),
    .resume_irq_enable(res_en), .resume_start(resume),
    .port_connect_raw(conn), .port_bias_raw(bias), .port_astat_raw(astat),
    .port_bstat_raw(bstat), .port_child(child), .port_speed(speed),
    .port_fault_error(fault), .selfid_contender(contender),
    .selfid_power_class(pclass), .sleep_notify_enable(notify),
    .short_arbitrated_reset_request(sbr_req), .accel_arb_enable(accel),
    .multi_speed_enable(multi), .port_disabled(disabled),
    .link_wake_irq(wake)
  );

  link_model link_model_i (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // pins just set by an edge are looked at mid-cycle, after its updates have landed; after a read, at the read's last edge
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    link_model_i.rd(a, d);
    chk_out(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(5);
    chk_rd(ADDR_SELFID, 8'hA2);
    chk_rd(ADDR_EVENT, 8'h08);
    chk_rd(ADDR_SELECT, 8'h00);
    chk_rd(4'h6, 8'h00);
    chk_out({5'h00, disabled}, 8'h00);
    link_model_i.wr(ADDR_SELFID, 8'h7E);
    chk_rd(ADDR_SELFID, 8'h62);
    @(negedge clk);
    chk_out({4'h0, pclass, contender}, 8'h07);
    $display("test selfid finished");
    link_model_i.wr(ADDR_EVENT, 8'hC9);
    chk_rd(ADDR_EVENT, 8'hC1);
    chk_out({5'h00, multi, accel, notify}, 8'h07);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      if (i == 2) pwr <= ~pwr;
      else ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 2'b00;
      @(negedge clk);
      chk_out({7'h00, wake}, (i < 2) ? 8'h01 : 8'h00);
      cyc(4);
      chk_rd(ADDR_EVENT, 8'hC1 | ev_mask[i]);
      link_model_i.wr(ADDR_EVENT, 8'hC1);
      chk_rd(ADDR_EVENT, 8'hC1 | ev_mask[i]);
      link_model_i.wr(ADDR_EVENT, 8'hC1 | ev_mask[i]);
      chk_rd(ADDR_EVENT, 8'hC1);
    end
    @(posedge clk) asleep <= 1'b0;
    @(posedge clk) ev[0] <= 1'b1;
    @(posedge clk) ev <= 2'b00;
    @(negedge clk);
    chk_out({7'h00, wake}, 8'h00);
    chk_rd(ADDR_EVENT, 8'hC5);
    link_model_i.wr(ADDR_EVENT, 8'hC5);
    link_model_i.wr(ADDR_EVENT, 8'hC3);
    chk_rd(ADDR_EVENT, 8'hC3);
    @(posedge clk) sbr_done <= 1'b1;
    @(posedge clk) sbr_done <= 1'b0;
    @(negedge clk);
    chk_out({7'h00, sbr_req}, 8'h00);
    @(posedge clk) resume <= 3'h4;
    @(posedge clk) resume <= 3'h0;
    chk_rd(ADDR_EVENT, 8'hE1);
    link_model_i.wr(ADDR_EVENT, 8'hE1);
    chk_rd(ADDR_EVENT, 8'hC1);
    $display("test events finished");
    @(posedge clk);
    astat <= 6'h0B;
    bstat <= 6'h07;
    child <= 3'h2;
    conn <= 3'h2;
    bias <= 3'h4;
    speed <= 9'h050;
    cyc(10);
    for (int p = 0; p < 3; p++) begin
      link_model_i.sel(p[3:0], PAGE_PORT_STATUS);
      chk_rd(ADDR_PORT_LINE, line_exp[p]);
      chk_rd(ADDR_PORT_SPEED, spd_exp[p]);
    end
    link_model_i.sel(4'h3, PAGE_PORT_STATUS);
    chk_rd(ADDR_PORT_LINE, 8'h00);
    link_model_i.sel(4'h1, 3'h1);
    chk_rd(ADDR_PORT_LINE, 8'h00);
    link_model_i.sel(4'h1, PAGE_PORT_STATUS);
    link_model_i.wr(ADDR_PORT_SPEED, 8'h10);
    chk_rd(ADDR_PORT_SPEED, 8'h50);
    link_model_i.wr(ADDR_PORT_LINE, 8'hF1);
    chk_rd(ADDR_PORT_LINE, 8'h9D);
    chk_out({5'h00, disabled}, 8'h02);
    chk_rd(ADDR_EVENT, 8'hE1);
    link_model_i.wr(ADDR_EVENT, 8'hE1);
    @(posedge clk) bias <= 3'h6;
    cyc(8);
    chk_rd(ADDR_PORT_LINE, 8'h9F);
    chk_rd(ADDR_EVENT, 8'hE1);
    @(posedge clk) fault <= 3'h2;
    @(posedge clk) fault <= 3'h0;
    chk_rd(ADDR_PORT_SPEED, 8'h58);
    link_model_i.wr(ADDR_PORT_SPEED, 8'h18);
    chk_rd(ADDR_PORT_SPEED, 8'h50);
    $display("test ports finished");
    complete_run();
  end

  initial begin
    cyc(20000);
    bad_count++;
    complete_run();
  end
endmodule // test_serial_bus_phy_port_registers
